// [shfc_tx.sv]
// Purpose: Packs the frame and multiplex parameter group once per frame
// Assumes: utc_midnight is a one-cycle pulse synchronous to clk
// Notes: Frame rate is an enable pulse from an internal divider
`timescale 1ns/1ps
// What this block does
// RQ1: Version field at bit 0, always zero
// RQ2: Reconfig flag marks next pipe configuration
// RQ3: Reconfig flag only for pipe multiplex changes
// RQ4: Receiver tolerates missing resync flag frames
// RQ5: Eleven-bit countdown, zero means nothing pending
// RQ6: Announcements at most 2047 frames ahead
// RQ7: Eight-bit network operator code at bit 16
// RQ8: Resync flag at bit 24 prepares receivers
// RQ9: Receiver resynchronizes when countdown reaches zero
// RQ10: Reschedule flag marks next stream schedule
// RQ11: Twenty-two-bit frame index advances per frame
// RQ12: Frame index forced to zero at midnight
// RQ13: Schedule period code is frames/2 minus one
// RQ14: Config index increments on each reconfiguration
// RQ15: Pipe count minus one; group 56 bits
// RQ16: Fields packed MSB first, ascending order
module shfc_tx import shfc_pkg::*; #(
  parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic utc_midnight,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  shfc_link_if.tx link
);

  localparam int DW = $clog2(FRAME_CYCLES + 1);

  typedef struct packed {
    logic [DW-1:0] div;
    logic enable;
    logic [7:0] operator_code;
    logic [CD_W-1:0] countdown;
    logic reconf_pend;
    logic resched_pend;
    logic resync_pend;
    logic [3:0] pipes_next;
    logic [3:0] pipes_cur;
    logic [1:0] period;
    logic [1:0] cfg_idx;
    logic [FIDX_W-1:0] frame_idx;
    logic zero_req;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic [31:0] rdata;
    shfc_group_t group;
    logic group_valid;
  } shfc_tx_state_t;

  shfc_tx_state_t s_r;
  shfc_tx_state_t s_nxt;
  logic tick;
  logic [IRQ_W-1:0] iset;
  logic [IRQ_W-1:0] iclr;
  logic [FIDX_W-1:0] fidx;
  shfc_group_t g;

  always_comb begin
    s_nxt = s_r;
    iset = '0;
    iclr = '0;
    g = s_r.group;
    tick = (s_r.div == DW'(FRAME_CYCLES - 1));
    fidx = s_r.zero_req ? '0 : s_r.frame_idx; // RQ12
    s_nxt.div = tick ? '0 : s_r.div + 1'b1;
    s_nxt.group_valid = 1'b0;
    s_nxt.rdata = '0;
    // Midnight request held until the next frame takes it
    if (utc_midnight) begin
      s_nxt.zero_req = 1'b1; // RQ12
    end
    if (tick) begin
      s_nxt.frame_idx = fidx + 1'b1; // RQ11
      s_nxt.zero_req = utc_midnight;
      if (s_r.zero_req) begin
        iset[IRQ_MIDNIGHT] = 1'b1;
      end
      if (s_r.countdown != '0) begin
        s_nxt.countdown = s_r.countdown - 1'b1; // RQ5
        if (s_r.countdown == CD_ONE) begin
          if (s_r.reconf_pend) begin
            s_nxt.cfg_idx = s_r.cfg_idx + 1'b1; // RQ14 RQ3
            s_nxt.pipes_cur = s_r.pipes_next;
          end
          s_nxt.reconf_pend = 1'b0;
          s_nxt.resched_pend = 1'b0;
          s_nxt.resync_pend = 1'b0;
          iset[IRQ_EVENT] = 1'b1;
        end
      end
      if (s_r.enable) begin
        g.version = SIG_VER; // RQ1
        g.reconfig = s_r.reconf_pend; // RQ2
        g.countdown = s_r.countdown; // RQ5
        g.network_operator_code = s_r.operator_code; // RQ7
        g.resync = s_r.resync_pend; // RQ8
        g.reschedule = s_r.resched_pend; // RQ10
        g.frame_idx = fidx; // RQ11
        g.sched_period = s_r.period; // RQ13
        // Flagged infoword already carries the next configuration
        g.cfg_idx = s_r.reconf_pend ? s_r.cfg_idx + 1'b1 : s_r.cfg_idx; // RQ2
        g.pipes_m1 = s_r.reconf_pend ? s_r.pipes_next : s_r.pipes_cur; // RQ15
        s_nxt.group = g; // RQ16
        s_nxt.group_valid = 1'b1;
        iset[IRQ_FRAME] = 1'b1;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          s_nxt.enable = reg_wdata[CTRL_EN_BIT];
        end
        REG_OPER: begin
          s_nxt.operator_code = reg_wdata[7:0];
        end
        REG_EVENT: begin
          // Eleven bits cap the lead time at 2047 frames
          s_nxt.countdown = reg_wdata[CD_W-1:0]; // RQ6
          s_nxt.reconf_pend = reg_wdata[EV_RECONF_BIT]; // RQ3
          s_nxt.resched_pend = reg_wdata[EV_RESCHED_BIT];
          s_nxt.resync_pend = reg_wdata[EV_RESYNC_BIT];
        end
        REG_MUX: begin
          s_nxt.pipes_next = reg_wdata[3:0];
          s_nxt.period = reg_wdata[MUX_PERIOD_LSB +: 2];
        end
        REG_ISTAT: begin
          iclr = reg_wdata[IRQ_W-1:0];
        end
        REG_IMASK: begin
          s_nxt.imask = reg_wdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over software clear
    s_nxt.ist = (s_r.ist & ~iclr) | iset;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
    // Read data stand one cycle, then drop back to zero
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: begin
          s_nxt.rdata[CTRL_EN_BIT] = s_r.enable;
        end
        REG_OPER: begin
          s_nxt.rdata[7:0] = s_r.operator_code;
        end
        REG_EVENT: begin
          s_nxt.rdata[CD_W-1:0] = s_r.countdown;
          s_nxt.rdata[EV_RECONF_BIT] = s_r.reconf_pend;
          s_nxt.rdata[EV_RESCHED_BIT] = s_r.resched_pend;
          s_nxt.rdata[EV_RESYNC_BIT] = s_r.resync_pend;
        end
        REG_MUX: begin
          s_nxt.rdata[3:0] = s_r.pipes_next;
          s_nxt.rdata[MUX_PERIOD_LSB +: 2] = s_r.period;
        end
        REG_STATE: begin
          s_nxt.rdata[CD_W-1:0] = s_r.countdown;
          s_nxt.rdata[ST_CFG_LSB +: 2] = s_r.cfg_idx;
          s_nxt.rdata[ST_PIPES_LSB +: 4] = s_r.pipes_cur;
          s_nxt.rdata[ST_FLAG_LSB +: 3] = {s_r.resync_pend,
                                           s_r.resched_pend,
                                           s_r.reconf_pend};
        end
        REG_FRAME: begin
          s_nxt.rdata[FIDX_W-1:0] = s_r.frame_idx;
        end
        REG_ISTAT: begin
          s_nxt.rdata[IRQ_W-1:0] = s_r.ist;
        end
        REG_IMASK: begin
          s_nxt.rdata[IRQ_W-1:0] = s_r.imask;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.imask <= IMASK_RST;
      s_r.pipes_cur <= PIPES_RST;
      s_r.pipes_next <= PIPES_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign irq = s_r.irq;
  assign link.group = s_r.group;
  assign link.group_valid = s_r.group_valid;

endmodule

// [shfc_pkg.sv]
// Purpose: Shared types and constants of the signalling header codec
// Assumes: One 250 MHz clock, frame rate derived by a divider
// Notes: Group word is 56 bits, first field in the top bits
package shfc_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int FRAME_MS = 432;
  localparam int FRAME_CYCLES_DEF = FRAME_MS * 1000000 / CLK_PERIOD_NS;

  localparam int GROUP_W = 56;
  localparam int CD_W = 11;
  localparam int FIDX_W = 22;
  localparam logic [3:0] SIG_VER = 4'h0;
  localparam logic [CD_W-1:0] CD_ONE = 11'h001;

  // Register byte offsets of the transmitter end
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPER = 8'h04;
  localparam logic [7:0] REG_EVENT = 8'h08;
  localparam logic [7:0] REG_MUX = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;
  localparam logic [7:0] REG_FRAME = 8'h14;
  localparam logic [7:0] REG_ISTAT = 8'h18;
  localparam logic [7:0] REG_IMASK = 8'h1c;

  // Field positions inside registers
  localparam int CTRL_EN_BIT = 0;
  localparam int EV_RECONF_BIT = 16;
  localparam int EV_RESCHED_BIT = 17;
  localparam int EV_RESYNC_BIT = 18;
  localparam int MUX_PERIOD_LSB = 8;
  localparam int ST_CFG_LSB = 16;
  localparam int ST_PIPES_LSB = 20;
  localparam int ST_FLAG_LSB = 24;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_EVENT = 1;
  localparam int IRQ_MIDNIGHT = 2;
  localparam int IRQ_W = 3;

  localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;
  localparam logic [3:0] PIPES_RST = 4'h0;

  // Parameter group, most significant bit first
  typedef struct packed {
    logic [3:0] version;
    logic reconfig;
    logic [CD_W-1:0] countdown;
    logic [7:0] network_operator_code;
    logic resync;
    logic reschedule;
    logic [FIDX_W-1:0] frame_idx;
    logic [1:0] sched_period;
    logic [1:0] cfg_idx;
    logic [3:0] pipes_m1;
  } shfc_group_t;

endpackage

// [shfc_link_if.sv]
// Purpose: Link between header packer and header parser
// Assumes: Both ends on the same clock
// Notes: group_valid is a one-cycle pulse per frame
`timescale 1ns/1ps
interface shfc_link_if import shfc_pkg::*; ();
  shfc_group_t group;
  logic group_valid;

  modport tx (
    output group,
    output group_valid
  );

  modport rx (
    input group,
    input group_valid
  );
endinterface

// [shfc_rx.sv]
// Purpose: Parses the frame and multiplex parameter group
// Assumes: One group_valid pulse per frame from the packer
// Notes: Event outputs are one-cycle pulses beside the fields
`timescale 1ns/1ps
module shfc_rx import shfc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  shfc_link_if.rx link,
  output logic frame_strobe,
  output logic version_err,
  output logic reconfig,
  output logic reschedule,
  output logic resync_armed,
  output logic [CD_W-1:0] countdown,
  output logic [7:0] network_operator_code,
  output logic [FIDX_W-1:0] frame_idx,
  output logic [3:0] period_frames,
  output logic [1:0] cfg_idx,
  output logic [4:0] num_pipes,
  output logic cfg_changed,
  output logic event_now,
  output logic resync_now
);

  typedef struct packed {
    shfc_group_t grp;
    logic seen;
    logic resync_pend;
    logic [3:0] period_frames;
    logic [4:0] num_pipes;
    logic strobe;
    logic ver_err;
    logic cfg_chg;
    logic event_now;
    logic resync_now;
  } shfc_rx_state_t;

  shfc_rx_state_t s_r;
  shfc_rx_state_t s_nxt;
  shfc_group_t g;

  always_comb begin
    s_nxt = s_r;
    g = link.group; // RQ16
    s_nxt.strobe = 1'b0;
    s_nxt.ver_err = 1'b0;
    s_nxt.cfg_chg = 1'b0;
    s_nxt.event_now = 1'b0;
    s_nxt.resync_now = 1'b0;
    if (link.group_valid) begin
      s_nxt.grp = g;
      s_nxt.seen = 1'b1;
      s_nxt.strobe = 1'b1;
      s_nxt.ver_err = (g.version != SIG_VER); // RQ1
      s_nxt.cfg_chg = s_r.seen && (g.cfg_idx != s_r.grp.cfg_idx); // RQ14
      s_nxt.period_frames = ({2'b00, g.sched_period} + 4'h1) << 1; // RQ13
      s_nxt.num_pipes = {1'b0, g.pipes_m1} + 5'h01; // RQ15
      // Pending resync held even if later frames drop the flag
      if (g.resync) begin
        s_nxt.resync_pend = 1'b1; // RQ8 RQ4
      end
      if (g.countdown == '0) begin
        s_nxt.event_now = s_r.seen && (s_r.grp.countdown != '0); // RQ5
        s_nxt.resync_now = s_r.resync_pend || g.resync; // RQ9
        s_nxt.resync_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign frame_strobe = s_r.strobe;
  assign version_err = s_r.ver_err;
  assign reconfig = s_r.grp.reconfig; // RQ2
  assign reschedule = s_r.grp.reschedule; // RQ10
  assign resync_armed = s_r.resync_pend;
  assign countdown = s_r.grp.countdown;
  assign network_operator_code = s_r.grp.network_operator_code;
  assign frame_idx = s_r.grp.frame_idx;
  assign period_frames = s_r.period_frames;
  assign cfg_idx = s_r.grp.cfg_idx;
  assign num_pipes = s_r.num_pipes;
  assign cfg_changed = s_r.cfg_chg;
  assign event_now = s_r.event_now;
  assign resync_now = s_r.resync_now;

endmodule

// [shfc_assertions.sv]
// Purpose: Link checks between header packer and parser
// Assumes: Enable never set again once cleared; rewrites keep the count
// Notes: Watches the shared link signals only
`timescale 1ns/1ps
module shfc_assertions import shfc_pkg::*; #(
  parameter int unsigned FRAME_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire shfc_group_t group,
  input wire logic group_valid
);
  logic seen_r;
  logic [31:0] gap_r;
  shfc_group_t last_r;
  // Last group and cycles since it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
      gap_r <= '0;
      last_r <= '0;
    end else if (group_valid) begin
      seen_r <= 1'b1;
      gap_r <= '0;
      last_r <= group;
    end else begin
      gap_r <= gap_r + 32'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_version_zero: assert property (
    group_valid |-> group.version == SIG_VER) else $error("version set");
  chk_valid_pulse: assert property (
    group_valid |=> !group_valid) else $error("valid too long");
  chk_group_hold: assert property (
    $changed(group) |-> group_valid) else $error("group moved");
  chk_frame_gap: assert property (
    group_valid && seen_r |-> gap_r == FRAME_CYCLES - 1)
    else $error("frame spacing");
  chk_index_step: assert property (
    group_valid && seen_r |-> group.frame_idx == last_r.frame_idx + 22'h1
    || group.frame_idx == '0) else $error("index step");
  chk_cd_step: assert property (
    group_valid && seen_r && last_r.countdown != '0
    |-> group.countdown == last_r.countdown - CD_ONE)
    else $error("countdown step");
  chk_idle_flags: assert property (
    group_valid && group.countdown == '0
    |-> !(group.reconfig || group.reschedule || group.resync))
    else $error("flag without countdown");
  chk_cfg_step: assert property (
    group_valid && seen_r && group.cfg_idx != last_r.cfg_idx
    |-> group.reconfig && group.cfg_idx == last_r.cfg_idx + 2'h1)
    else $error("config index step");
  cover property (group_valid && group.reconfig);
  cover property (group_valid && group.resync);
  cover property (group_valid && group.countdown == 11'h7ff);
  cover property (group_valid && seen_r && group.frame_idx == '0);
endmodule

// [shfc_tb.sv]
// Purpose: Self-checking bench for packer and parser pair
// Assumes: Short frames through FRAME_CYCLES
// Notes: Expected fields are tracked by the bench
`timescale 1ns/1ps
module shfc_tb import shfc_pkg::*;;
  localparam int FC = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic utc_midnight = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, r;
  logic irq, frame_strobe, version_err, reconfig, reschedule;
  logic resync_armed, cfg_changed, event_now, resync_now, ev, rs, cc, trk;
  logic [CD_W-1:0] countdown;
  logic [7:0] network_operator_code, e_op;
  logic [FIDX_W-1:0] frame_idx, e_idx;
  logic [3:0] period_frames, e_p;
  logic [1:0] cfg_idx, e_cfg, e_code;
  logic [4:0] num_pipes;
  logic [31:0] seed = 32'hc7c74a30;
  int mismatches = 0;
  int checks = 0;
  int n;
  always #2 clk = ~clk;
  shfc_link_if shfc_link_if_i ();
  shfc_tx #(.FRAME_CYCLES(FC)) shfc_tx_i (.clk, .rst_n, .utc_midnight,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .link(shfc_link_if_i.tx));
  shfc_rx shfc_rx_i (.clk, .rst_n, .link(shfc_link_if_i.rx), .frame_strobe,
    .version_err, .reconfig, .reschedule, .resync_armed, .countdown,
    .network_operator_code, .frame_idx, .period_frames, .cfg_idx,
    .num_pipes, .cfg_changed, .event_now, .resync_now);
  shfc_assertions #(.FRAME_CYCLES(FC)) shfc_assertions_i (.clk, .rst_n,
    .group(shfc_link_if_i.group), .group_valid(shfc_link_if_i.group_valid));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] period(input logic [1:0] c);
    return ({2'h0, c} + 4'h1) * 4'h2;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp("rdata", reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic cirq(input logic e);
    @(negedge clk);
    cmp("irq", irq, e);
    @(posedge clk);
  endtask
  // Waits for one parsed frame, checks the level fields
  task automatic wframe;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (frame_strobe !== 1'b1 && i < 4 * FC);
    cmp("frame", frame_strobe, 1'b1);
    ev = event_now;
    rs = resync_now;
    cc = cfg_changed;
    cmp("oper", network_operator_code, e_op);
    cmp("period", period_frames, period(e_code));
    cmp("pipes", num_pipes, {1'b0, e_p} + 5'h1);
    cmp("cfg", cfg_idx, e_cfg);
    cmp("ver", version_err, 1'b0);
    if (trk) begin
      cmp("idx", frame_idx, e_idx);
      e_idx++;
    end
    @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(REG_IMASK, {29'h0, IMASK_RST});
    rd(8'h20, 32'h0);
    $display("test reset done");
    r = rnd();
    {e_code, e_op} = r[9:0];
    {e_p, e_cfg, trk} = '0;
    wr(REG_OPER, r & 32'hff);
    wr(REG_MUX, r & 32'h300);
    wr(REG_CTRL, 32'h1);
    rd(REG_OPER, {24'h0, e_op});
    rd(REG_MUX, {22'h0, e_code, 8'h0});
    rd(REG_CTRL, 32'h1);
    wframe;
    utc_midnight <= 1'b1;
    @(posedge clk);
    utc_midnight <= 1'b0;
    {trk, e_idx} = {1'b1, 22'h0};
    wframe;
    wframe;
    rd(REG_FRAME, {10'h0, e_idx});
    $display("test midnight done");
    wr(REG_ISTAT, 32'h7);
    wframe;
    cirq(1'b0);
    rd(REG_ISTAT, 32'h1);
    wr(REG_IMASK, 32'h1);
    cirq(1'b1);
    wr(REG_ISTAT, 32'h1);
    cirq(1'b0);
    $display("test irq done");
    for (int k = 0; k < 3; k++) begin
      wframe;
      r = rnd();
      n = k == 1 ? 2047 : k == 0 ? int'(r[1:0]) + 1 : 1;
      if (k == 0) begin
        e_p = r[7:4];
        e_cfg++;
        wr(REG_MUX, {22'h0, e_code, 4'h0, e_p});
      end
      wr(REG_EVENT, (32'h1 << (EV_RECONF_BIT + k)) | n);
      for (int j = n; j >= 0; j--) begin
        wframe;
        cmp("cd", countdown, j);
        cmp("rcf", reconfig, k == 0 && j != 0);
        cmp("rsc", reschedule, k == 1 && j != 0);
        cmp("arm", resync_armed, k == 2 && j != 0);
        cmp("evt", ev, j == 0);
        cmp("rsn", rs, k == 2 && j == 0);
        cmp("chg", cc, k == 0 && j == n);
      end
      $display("test event %0d done", k);
    end
    wr(REG_EVENT, (32'h1 << EV_RESYNC_BIT) | 32'h2);
    wframe;
    cmp("cd", countdown, 32'h2);
    cmp("arm", resync_armed, 1'b1);
    // Flag dropped while the count runs on
    wr(REG_EVENT, 32'h1);
    wframe;
    cmp("cd", countdown, 32'h1);
    cmp("arm", resync_armed, 1'b1);
    cmp("rsn", rs, 1'b0);
    wframe;
    cmp("evt", ev, 1'b1);
    cmp("rsn", rs, 1'b1);
    $display("test resync hold done");
    rd(REG_ISTAT, 32'h3);
    rd(REG_STATE, {8'h0, e_p, 2'h0, e_cfg, 16'h0});
    wr(REG_CTRL, 32'h0);
    n = 0;
    repeat (2 * FC) begin
      @(negedge clk);
      n += int'(frame_strobe === 1'b1);
    end
    cmp("off", n, 32'h0);
    $display("test disable done");
    test_done;
  end
  initial begin
    #(FC * 4 * 2400);
    mismatches++;
    test_done;
  end
endmodule
